// ===== verilog/fpsc_top.sv
// Fuse controller command, clock/power control and error status over AXI4-Lite
// Behaviour
// - Repeat-error bits read-only, one marks failed bit
// - Read-only error byte count per block 1-10
// - Failure flag set when error bytes exceed six
// - Force power-down puts fuse memory into power-save unless force power-up is also set
// - Force power-up keeps fuse memory working
// - Memory clock force-on bypasses automatic gating
// - Fuse clock enable forces fuse memory clock on
// - Code 0x5A5A authorises programming command
// - Code 0x5AA5 authorises read command
// - Read trigger launches read, self-clears
// - Program trigger launches programming, self-clears
// - Block index 0-10 selects programming target
// - Read-only controller state field
// - Read-only block zero error bit count
// - Read completion sets clearable read-done event
// - Program completion sets clearable program-done event
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module fpsc_top
(
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  // Register bus
  input  wire fpsc_pkg::fpsc_axi_req_s axi_req_i,
  output      fpsc_pkg::fpsc_axi_rsp_s axi_rsp_o,
  // Fuse array engine
  input  wire fpsc_pkg::fpsc_fuse_in_s fuse_i,
  output      fpsc_pkg::fpsc_fuse_out_s fuse_o,
  // Memory clock and power
  output      fpsc_pkg::fpsc_mem_ctl_s mem_o,
  // Interrupt
  output      logic                    irq_o
);
  import fpsc_pkg::*;

  // A literal cannot be bit-selected, so the reset word is named first
  localparam logic [31:0] RST_CLK = `FPSC_RST_CLK;

  typedef struct packed
  {
    fpsc_state_e               st;
    logic                      aw_rdy;
    logic                      w_rdy;
    logic                      have_aw;
    logic                      have_w;
    logic [`FPSC_AXI_AW-1:0]   awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      ar_rdy;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic                      f_pd;
    logic                      f_clk_on;
    logic                      f_pu;
    logic                      f_clk_en;
    logic [15:0]               opcode;
    logic                      cmd_rd;
    logic                      cmd_pgm;
    logic [3:0]                blk;
    logic [4:0][31:0]          rpt;
    logic [1:0][31:0]          sum;
    logic [`FPSC_B0_CNT_W-1:0] b0cnt;
    logic [1:0]                raw;
    logic [1:0]                mask;
    logic                      irq;
    fpsc_mem_ctl_s             mem;
    fpsc_fuse_out_s            fz;
  } fpsc_regs_s;

  fpsc_regs_s s_ff;
  fpsc_regs_s nxt_s;
  logic       wr_go;
  logic       rd_end;
  logic       pgm_end;
  logic [3:0] blk1_cnt;
  logic [4:0][31:0] rpt_in;

  function automatic logic [31:0] fpsc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    end
    return res;
  endfunction : fpsc_merge

  assign wr_go    = s_ff.have_aw && s_ff.have_w && !s_ff.bvalid;
  assign rd_end   = (s_ff.st == ST_READ) && fuse_i.done;
  assign pgm_end  = (s_ff.st == ST_PROG) && fuse_i.done;
  assign blk1_cnt = fuse_i.blk_cnt[0];
  assign rpt_in   = fuse_i.rpt_err;

  always_comb
  begin
    logic [31:0] clk_w;
    logic [31:0] cmd_w;
    logic [31:0] wv;
    logic [`FPSC_AXI_AW-1:0] ra;
    logic [`FPSC_AXI_AW-1:0] wa;
    nxt_s = s_ff;
    clk_w = 32'h0000_0000;
    clk_w[`FPSC_CLK_PD_BIT] = s_ff.f_pd;
    clk_w[`FPSC_CLK_ON_BIT] = s_ff.f_clk_on;
    clk_w[`FPSC_CLK_PU_BIT] = s_ff.f_pu;
    clk_w[`FPSC_CLK_EN_BIT] = s_ff.f_clk_en;
    cmd_w = 32'h0000_0000;
    cmd_w[`FPSC_CMD_RD_BIT] = s_ff.cmd_rd;
    cmd_w[`FPSC_CMD_PGM_BIT] = s_ff.cmd_pgm;
    cmd_w[`FPSC_CMD_BLK_LSB +: 4] = s_ff.blk;
    wv = 32'h0000_0000;
    ra = axi_req_i.araddr;
    wa = s_ff.awaddr;

    // Address and data are taken independently, in either order
    if (s_ff.aw_rdy && axi_req_i.awvalid)
    begin
      nxt_s.aw_rdy  = 1'b0;
      nxt_s.have_aw = 1'b1;
      nxt_s.awaddr  = axi_req_i.awaddr;
    end
    if (s_ff.w_rdy && axi_req_i.wvalid)
    begin
      nxt_s.w_rdy  = 1'b0;
      nxt_s.have_w = 1'b1;
      nxt_s.wdata  = axi_req_i.wdata;
      nxt_s.wstrb  = axi_req_i.wstrb;
    end
    if (s_ff.bvalid && axi_req_i.bready)
    begin
      nxt_s.bvalid = 1'b0;
      nxt_s.aw_rdy = 1'b1;
      nxt_s.w_rdy  = 1'b1;
    end

    // Operation sequencer; a trigger is only acted on from idle
    case (s_ff.st)
      ST_IDLE:
      begin
        if (s_ff.cmd_rd)
        begin
          if (s_ff.opcode == `FPSC_OP_RD)
          begin
            nxt_s.st        = ST_READ;
            nxt_s.fz.rd_req = 1'b1;
          end
          else
            nxt_s.cmd_rd = 1'b0;
        end
        else if (s_ff.cmd_pgm)
        begin
          if (s_ff.opcode == `FPSC_OP_PGM &&
              s_ff.blk <= `FPSC_BLK_MAX)
          begin
            nxt_s.st         = ST_PROG;
            nxt_s.fz.pgm_req = 1'b1;
            nxt_s.fz.blk     = s_ff.blk;
          end
          else
            nxt_s.cmd_pgm = 1'b0;
        end
      end
      ST_READ:
      begin
        if (fuse_i.done)
        begin
          nxt_s.st        = ST_IDLE;
          nxt_s.fz.rd_req = 1'b0;
          nxt_s.cmd_rd    = 1'b0;
          nxt_s.rpt       = fuse_i.rpt_err;
          nxt_s.b0cnt     = fuse_i.blk0_bits;
          // Count field is three bits wide, so larger counts saturate
          for (int k = 0; k < 10; k++)
          begin
            nxt_s.sum[k/8][4*(k%8) +: 3] =
              (fuse_i.blk_cnt[k] > `FPSC_CNT_SAT) ? 3'h7
              : fuse_i.blk_cnt[k][2:0];
            nxt_s.sum[k/8][4*(k%8) + 3] =
              (fuse_i.blk_cnt[k] > `FPSC_FAIL_LIMIT);
          end
        end
      end
      ST_PROG:
      begin
        if (fuse_i.done)
        begin
          nxt_s.st         = ST_IDLE;
          nxt_s.fz.pgm_req = 1'b0;
          nxt_s.cmd_pgm    = 1'b0;
        end
      end
      default:
      begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    // Register writes; a write of zero to a trigger leaves it alone
    if (wr_go)
    begin
      nxt_s.have_aw = 1'b0;
      nxt_s.have_w  = 1'b0;
      nxt_s.bvalid  = 1'b1;
      nxt_s.bresp   = `FPSC_RESP_OK;
      if (wa == `FPSC_OFF_CLK)
      begin
        wv = fpsc_merge(clk_w, s_ff.wdata, s_ff.wstrb);
        nxt_s.f_pd     = wv[`FPSC_CLK_PD_BIT];
        nxt_s.f_clk_on = wv[`FPSC_CLK_ON_BIT];
        nxt_s.f_pu     = wv[`FPSC_CLK_PU_BIT];
        nxt_s.f_clk_en = wv[`FPSC_CLK_EN_BIT];
      end
      else if (wa == `FPSC_OFF_CONF)
      begin
        wv = fpsc_merge({16'h0000, s_ff.opcode}, s_ff.wdata, s_ff.wstrb);
        nxt_s.opcode = wv[15:0];
      end
      else if (wa == `FPSC_OFF_CMD)
      begin
        wv = fpsc_merge(cmd_w, s_ff.wdata, s_ff.wstrb);
        if (wv[`FPSC_CMD_RD_BIT])
          nxt_s.cmd_rd = 1'b1;
        if (wv[`FPSC_CMD_PGM_BIT])
          nxt_s.cmd_pgm = 1'b1;
        nxt_s.blk = wv[`FPSC_CMD_BLK_LSB +: 4];
      end
      else if (wa == `FPSC_OFF_RAW)
      begin
        if (s_ff.wstrb[0])
          nxt_s.raw = s_ff.raw & ~s_ff.wdata[1:0];
      end
      else if (wa == `FPSC_OFF_MASK)
      begin
        if (s_ff.wstrb[0])
          nxt_s.mask = s_ff.wdata[1:0];
      end
      else if (wa == `FPSC_OFF_RPT0 || wa == `FPSC_OFF_RPT1 ||
               wa == `FPSC_OFF_RPT2 || wa == `FPSC_OFF_RPT3 ||
               wa == `FPSC_OFF_RPT4 || wa == `FPSC_OFF_SUM0 ||
               wa == `FPSC_OFF_SUM1 || wa == `FPSC_OFF_STAT ||
               wa == `FPSC_OFF_MST)
        nxt_s.bresp = `FPSC_RESP_OK;
      else
        nxt_s.bresp = `FPSC_RESP_SLVERR;
    end

    // Reads answer one cycle after the address is taken
    if (s_ff.rvalid && axi_req_i.rready)
    begin
      nxt_s.rvalid = 1'b0;
      nxt_s.ar_rdy = 1'b1;
    end
    if (s_ff.ar_rdy && axi_req_i.arvalid)
    begin
      nxt_s.ar_rdy = 1'b0;
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = `FPSC_RESP_OK;
      nxt_s.rdata  = 32'h0000_0000;
      if (ra == `FPSC_OFF_RPT0)
        nxt_s.rdata = s_ff.rpt[0];
      else if (ra == `FPSC_OFF_RPT1)
        nxt_s.rdata = s_ff.rpt[1];
      else if (ra == `FPSC_OFF_RPT2)
        nxt_s.rdata = s_ff.rpt[2];
      else if (ra == `FPSC_OFF_RPT3)
        nxt_s.rdata = s_ff.rpt[3];
      else if (ra == `FPSC_OFF_RPT4)
        nxt_s.rdata = s_ff.rpt[4];
      else if (ra == `FPSC_OFF_SUM0)
        nxt_s.rdata = s_ff.sum[0];
      else if (ra == `FPSC_OFF_SUM1)
        nxt_s.rdata = s_ff.sum[1];
      else if (ra == `FPSC_OFF_CLK)
        nxt_s.rdata = clk_w;
      else if (ra == `FPSC_OFF_CONF)
        nxt_s.rdata = {16'h0000, s_ff.opcode};
      else if (ra == `FPSC_OFF_STAT)
      begin
        nxt_s.rdata[2:0] = s_ff.st;
        nxt_s.rdata[`FPSC_STAT_CNT_LSB +: `FPSC_B0_CNT_W] =
          s_ff.b0cnt;
      end
      else if (ra == `FPSC_OFF_CMD)
        nxt_s.rdata = cmd_w;
      else if (ra == `FPSC_OFF_RAW)
      begin
        nxt_s.rdata[1:0] = s_ff.raw;
        nxt_s.raw        = 2'b00;
      end
      else if (ra == `FPSC_OFF_MST)
        nxt_s.rdata[1:0] = s_ff.raw & s_ff.mask;
      else if (ra == `FPSC_OFF_MASK)
        nxt_s.rdata[1:0] = s_ff.mask;
      else
        nxt_s.rresp = `FPSC_RESP_SLVERR;
    end

    // Events applied last so a same-cycle clear cannot lose them
    if (rd_end)
      nxt_s.raw[0] = 1'b1;
    if (pgm_end)
      nxt_s.raw[1] = 1'b1;

    // Power-up wins over power-down; a live operation does not hold off power-down
    nxt_s.mem.mem_pd = nxt_s.f_pd && !nxt_s.f_pu;
    nxt_s.mem.mem_pu = nxt_s.f_pu;
    nxt_s.mem.mem_clk_on = nxt_s.f_clk_on || (nxt_s.st != ST_IDLE);
    nxt_s.mem.fuse_clk_on = nxt_s.f_clk_en || (nxt_s.st != ST_IDLE);
    nxt_s.irq = |(nxt_s.raw & nxt_s.mask);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_ff          <= '0;
      s_ff.st       <= ST_IDLE;
      s_ff.aw_rdy   <= 1'b1;
      s_ff.w_rdy    <= 1'b1;
      s_ff.ar_rdy   <= 1'b1;
      s_ff.f_pd     <= RST_CLK[`FPSC_CLK_PD_BIT];
      s_ff.f_clk_on <= RST_CLK[`FPSC_CLK_ON_BIT];
      s_ff.f_pu     <= RST_CLK[`FPSC_CLK_PU_BIT];
      s_ff.f_clk_en <= RST_CLK[`FPSC_CLK_EN_BIT];
      s_ff.opcode   <= `FPSC_RST_OP;
      s_ff.blk      <= `FPSC_RST_BLK;
      s_ff.mask     <= `FPSC_RST_MASK;
    end
    else
      s_ff <= nxt_s;
  end

  assign axi_rsp_o.awready = s_ff.aw_rdy;
  assign axi_rsp_o.wready  = s_ff.w_rdy;
  assign axi_rsp_o.bvalid  = s_ff.bvalid;
  assign axi_rsp_o.bresp   = s_ff.bresp;
  assign axi_rsp_o.arready = s_ff.ar_rdy;
  assign axi_rsp_o.rvalid  = s_ff.rvalid;
  assign axi_rsp_o.rdata   = s_ff.rdata;
  assign axi_rsp_o.rresp   = s_ff.rresp;
  assign fuse_o            = s_ff.fz;
  assign mem_o             = s_ff.mem;
  assign irq_o             = s_ff.irq;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_read_launch: assert property (
    s_ff.st == ST_IDLE && s_ff.cmd_rd && s_ff.opcode == `FPSC_OP_RD
    |=> s_ff.st == ST_READ && fuse_o.rd_req)
    else $error("authorised read not launched");
  a_bad_code: assert property (
    s_ff.st == ST_IDLE && s_ff.cmd_rd && s_ff.opcode != `FPSC_OP_RD &&
    !wr_go |=> !s_ff.cmd_rd && s_ff.st == ST_IDLE && !fuse_o.rd_req)
    else $error("unauthorised read not dropped");
  a_prog_launch: assert property (
    s_ff.st == ST_IDLE && !s_ff.cmd_rd && s_ff.cmd_pgm &&
    s_ff.opcode == `FPSC_OP_PGM && s_ff.blk <= `FPSC_BLK_MAX
    |=> s_ff.st == ST_PROG && fuse_o.pgm_req &&
        fuse_o.blk == $past(s_ff.blk))
    else $error("authorised program not launched");
  a_blk_range: assert property (
    s_ff.st == ST_IDLE && !s_ff.cmd_rd && s_ff.cmd_pgm &&
    s_ff.blk > `FPSC_BLK_MAX && !wr_go |=> !s_ff.cmd_pgm && !fuse_o.pgm_req)
    else $error("out of range block programmed");
  a_read_clear: assert property (
    rd_end && !wr_go |=> !s_ff.cmd_rd && !fuse_o.rd_req ##1 !fuse_o.rd_req)
    else $error("read trigger did not self-clear");
  a_prog_clear: assert property (
    pgm_end && !wr_go |=> !s_ff.cmd_pgm && s_ff.st == ST_IDLE)
    else $error("program trigger did not self-clear");
  a_read_event: assert property (
    rd_end |=> s_ff.raw[0])
    else $error("read done event lost");
  a_prog_event: assert property (
    pgm_end |=> s_ff.raw[1] && (irq_o || !s_ff.mask[1]))
    else $error("program done event lost");
  a_fail_flag: assert property (
    rd_end |=> s_ff.sum[0][3] == ($past(blk1_cnt) > `FPSC_FAIL_LIMIT))
    else $error("failure flag wrong");
  a_err_refresh: assert property (
    rd_end |=> s_ff.rpt == $past(rpt_in))
    else $error("repeat errors not refreshed");
  a_clk_busy: assert property (
    fuse_o.rd_req || fuse_o.pgm_req |-> mem_o.mem_clk_on && mem_o.fuse_clk_on)
    else $error("memory clock gated during operation");
  a_power_pu: assert property (
    $rose(s_ff.f_pu) |-> mem_o.mem_pu && !mem_o.mem_pd)
    else $error("force power-up not honoured");
endmodule : fpsc_top

// ===== verilog/fpsc_cfg.svh
// Register map, field positions, codes and reset values of the fuse command block
`ifndef FPSC_CFG_SVH
`define FPSC_CFG_SVH
`define FPSC_AXI_AW        12
`define FPSC_B0_CNT_W      8
`define FPSC_OFF_RPT0      12'h17C
`define FPSC_OFF_RPT1      12'h180
`define FPSC_OFF_RPT2      12'h184
`define FPSC_OFF_RPT3      12'h188
`define FPSC_OFF_RPT4      12'h190
`define FPSC_OFF_SUM0      12'h1C0
`define FPSC_OFF_SUM1      12'h1C4
`define FPSC_OFF_CLK       12'h1C8
`define FPSC_OFF_CONF      12'h1CC
`define FPSC_OFF_STAT      12'h1D0
`define FPSC_OFF_CMD       12'h1D4
`define FPSC_OFF_RAW       12'h1D8
`define FPSC_OFF_MST       12'h1DC
`define FPSC_OFF_MASK      12'h1E0
`define FPSC_CLK_PD_BIT    0
`define FPSC_CLK_ON_BIT    1
`define FPSC_CLK_PU_BIT    2
`define FPSC_CLK_EN_BIT    16
`define FPSC_CMD_RD_BIT    0
`define FPSC_CMD_PGM_BIT   1
`define FPSC_CMD_BLK_LSB   2
`define FPSC_STAT_CNT_LSB  8
`define FPSC_OP_PGM        16'h5A5A
`define FPSC_OP_RD         16'h5AA5
`define FPSC_RST_CLK       32'h0000_0000
`define FPSC_RST_OP        16'h0000
`define FPSC_RST_BLK       4'h0
`define FPSC_RST_MASK      2'h0
`define FPSC_BLK_MAX       4'hA
`define FPSC_FAIL_LIMIT    4'h6
`define FPSC_CNT_SAT       4'h7
`define FPSC_RESP_OK       2'b00
`define FPSC_RESP_SLVERR   2'b10
`endif

// ===== verilog/fpsc_pkg.sv
// Types shared by the fuse command block and its bench
package fpsc_pkg;
  `include "fpsc_cfg.svh"

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_PROG = 3'b100
  } fpsc_state_e;

  typedef struct packed
  {
    logic                     awvalid;
    logic [`FPSC_AXI_AW-1:0]  awaddr;
    logic                     wvalid;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bready;
    logic                     arvalid;
    logic [`FPSC_AXI_AW-1:0]  araddr;
    logic                     rready;
  } fpsc_axi_req_s;

  typedef struct packed
  {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fpsc_axi_rsp_s;

  typedef struct packed
  {
    logic                      done;
    logic [4:0][31:0]          rpt_err;
    logic [9:0][3:0]           blk_cnt;
    logic [`FPSC_B0_CNT_W-1:0] blk0_bits;
  } fpsc_fuse_in_s;

  typedef struct packed
  {
    logic       rd_req;
    logic       pgm_req;
    logic [3:0] blk;
  } fpsc_fuse_out_s;

  typedef struct packed
  {
    logic mem_pd;
    logic mem_pu;
    logic mem_clk_on;
    logic fuse_clk_on;
  } fpsc_mem_ctl_s;
endpackage : fpsc_pkg

// ===== verif/fpsc_fuse_model.sv
// Fuse array stand-in that answers each request with a done pulse
`timescale 1ns/1ns
module fpsc_fuse_model
(
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  // Controller side
  input  wire fpsc_pkg::fpsc_fuse_out_s fuse_i,
  output      fpsc_pkg::fpsc_fuse_in_s  fuse_o,
  // Bench controls: array image and answer latency
  input  wire fpsc_pkg::fpsc_fuse_in_s  img_i,
  input  wire logic [3:0]               lat_i
);
  import fpsc_pkg::*;
  logic [3:0] cnt_ff;
  logic       fired_ff;
  logic       done_ff;

  // Status lines are sense outputs of the array, so they always carry data
  always_comb
  begin
    fuse_o      = img_i;
    fuse_o.done = done_ff;
  end

  // One pulse per request; a held request never earns a second done
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_ff   <= 4'h0;
      fired_ff <= 1'b0;
      done_ff  <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (!(fuse_i.rd_req | fuse_i.pgm_req))
      begin
        cnt_ff   <= 4'h0;
        fired_ff <= 1'b0;
      end
      else if (!fired_ff)
      begin
        if (cnt_ff == lat_i)
        begin
          done_ff  <= 1'b1;
          fired_ff <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule : fpsc_fuse_model

// ===== verif/tb_top.sv
// Self-checking bench for the fuse command block
`timescale 1ns/1ns
`include "fpsc_cfg.svh"
module tb_top;
  import fpsc_pkg::*;
  logic           sys_clk;
  logic           rst;
  fpsc_axi_req_s  req;
  fpsc_axi_rsp_s  rsp;
  fpsc_fuse_in_s  fin;
  fpsc_fuse_in_s  img;
  fpsc_fuse_out_s fout;
  fpsc_mem_ctl_s  mem;
  logic           irq;
  logic [3:0]     lat;
  logic [31:0]    seed;
  logic [31:0]    d;
  logic [31:0]    v;
  logic [31:0]    old;
  logic [1:0]     r;
  logic [11:0]    ofs [5];
  logic [15:0]    bad_op [4];
  logic [31:0]    bad_cmd [4];
  int             n_errors;
  int             num_checks;

  fpsc_top u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .axi_req_i(req),
    .axi_rsp_o(rsp), .fuse_i(fin), .fuse_o(fout), .mem_o(mem), .irq_o(irq));
  fpsc_fuse_model u_fuse (.sys_clk_i(sys_clk), .rst_i(rst), .fuse_i(fout),
    .fuse_o(fin), .img_i(img), .lat_i(lat));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Nibble per block: saturated count in [2:0], failure above six in [3]
  function automatic logic [31:0] exp_sum(input fpsc_fuse_in_s f, input int i);
    logic [31:0] s;
    s = 32'h0000_0000;
    for (int k = 0; k < 10; k++)
      if (k / 8 == i)
        s[(k % 8) * 4 +: 4] = {f.blk_cnt[k] > 4'h6,
          (f.blk_cnt[k] > 4'h7) ? 3'h7 : f.blk_cnt[k][2:0]};
    return s;
  endfunction : exp_sum

  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Handshakes are judged at the negedge, where the next rising edge's view holds
  task automatic wr(input logic [11:0] a, input logic [31:0] dv,
                    output logic [1:0] rs);
    logic ah;
    logic wh;
    logic bh;
    int   n;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= dv;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    rs = 2'b11;
    for (n = 0; n < 64; n++)
    begin
      @(negedge sys_clk);
      ah = req.awvalid & rsp.awready;
      wh = req.wvalid & rsp.wready;
      bh = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge sys_clk);
      if (ah) req.awvalid <= 1'b0;
      if (wh) req.wvalid <= 1'b0;
      if (bh)
      begin
        req.bready <= 1'b0;
        break;
      end
    end
    if (n == 64) chk(32'h0000_0000, 32'h0000_0001);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] dv,
                    output logic [1:0] rs);
    logic ah;
    logic vh;
    int   n;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(negedge sys_clk);
      ah = req.arvalid & rsp.arready;
      vh = rsp.rvalid;
      dv = rsp.rdata;
      rs = rsp.rresp;
      @(posedge sys_clk);
      if (ah) req.arvalid <= 1'b0;
      if (vh)
      begin
        req.rready <= 1'b0;
        break;
      end
    end
    if (n == 64) chk(32'h0000_0000, 32'h0000_0001);
  endtask : rd

  task automatic wchk(input logic [11:0] a, input logic [31:0] dv);
    wr(a, dv, r);
    chk(32'(r), 32'h0000_0000);
  endtask : wchk

  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
    rd(a, d, r);
    chk({d & m, 30'h0, r}, {e, 32'h0000_0000});
  endtask : rchk

  task automatic rnd_img(input logic [3:0] c1);
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      img.rpt_err[k] <= seed;
    end
    for (int k = 3; k < 10; k++)
    begin
      seed = lfsr(seed);
      img.blk_cnt[k] <= seed[3:0];
    end
    img.blk_cnt[0] <= c1;
    img.blk_cnt[1] <= 4'h7;
    img.blk_cnt[2] <= 4'hF;
    seed = lfsr(seed);
    img.blk0_bits <= seed[7:0];
    lat <= {1'b0, seed[10:8]} + 4'h2;
    @(posedge sys_clk);
  endtask : rnd_img

  // Launch, busy clocks forced on, target block shown, then completion
  task automatic run_op(input logic pgm, input logic [3:0] b);
    int n;
    for (n = 0; n < 32 && !(pgm ? fout.pgm_req : fout.rd_req); n++)
      @(negedge sys_clk);
    chk(32'(n < 32), 32'h0000_0001);
    @(negedge sys_clk);
    chk({mem.mem_clk_on, mem.fuse_clk_on}, 2'h3);
    if (pgm) chk(32'(fout.blk), 32'(b));
    for (n = 0; n < 64 && (fout.rd_req | fout.pgm_req); n++)
      @(negedge sys_clk);
    chk(32'(n < 64), 32'h0000_0001);
    @(negedge sys_clk);
  endtask : run_op

  task automatic no_op();
    logic seen;
    seen = 1'b0;
    repeat (8)
    begin
      @(negedge sys_clk);
      seen = seen | fout.rd_req | fout.pgm_req;
    end
    chk(32'(seen), 32'h0000_0000);
  endtask : no_op

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    rst = 1'b1;
    req = '0;
    img = '0;
    lat = 4'h2;
    seed = 32'h0000_0050;
    n_errors = 0;
    num_checks = 0;
    ofs = '{`FPSC_OFF_RPT0, `FPSC_OFF_RPT1, `FPSC_OFF_RPT2, `FPSC_OFF_RPT3,
            `FPSC_OFF_RPT4};
    bad_op = '{16'h5A5A, 16'h5AA5, 16'h5A5A, 16'h0000};
    bad_cmd = '{32'h0000_0001, 32'h0000_0006, 32'h0000_002E, 32'h0000_0001};
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(`FPSC_OFF_CLK, 32'h0000_0000);
    rchk(`FPSC_OFF_CONF, 32'h0000_0000);
    rchk(`FPSC_OFF_CMD, 32'h0000_0000);
    rchk(`FPSC_OFF_STAT, 32'h0000_0001, 32'h0000_0007);
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      v = {15'h0000, i[3], 13'h0000, i[2:0]};
      wchk(`FPSC_OFF_CLK, v | (seed & 32'hFFFE_FFF8));
      rchk(`FPSC_OFF_CLK, v);
      @(negedge sys_clk);
      chk(32'(mem), {28'h0, i[0] & ~i[2], i[2], i[1], i[3]});
    end
    wchk(`FPSC_OFF_CLK, 32'h0000_0000);
    wchk(`FPSC_OFF_MASK, 32'h0000_0003);
    for (int t = 0; t < 3; t++)
    begin
      rnd_img(4'h6 + 4'(t));
      wchk(`FPSC_OFF_CONF, 32'h0000_5AA5);
      wchk(`FPSC_OFF_CMD, 32'h0000_0001);
      run_op(1'b0, 4'h0);
      chk(32'(irq), 32'h0000_0001);
      rchk(`FPSC_OFF_MST, 32'h0000_0001);
      rchk(`FPSC_OFF_RAW, 32'h0000_0001);
      rchk(`FPSC_OFF_RAW, 32'h0000_0000);
      @(negedge sys_clk);
      chk(32'(irq), 32'h0000_0000);
      rchk(`FPSC_OFF_CMD, 32'h0000_0000);
      rchk(`FPSC_OFF_STAT, {16'h0, img.blk0_bits, 8'h01});
      for (int k = 0; k < 5; k++)
        rchk(ofs[k], img.rpt_err[k]);
      rchk(`FPSC_OFF_SUM0, exp_sum(img, 0));
      rchk(`FPSC_OFF_SUM1, exp_sum(img, 1));
    end
    wchk(ofs[0], ~img.rpt_err[0]);
    rchk(ofs[0], img.rpt_err[0]);
    // Wrong code, or a block beyond ten, must only clear the trigger
    for (int j = 0; j < 4; j++)
    begin
      wchk(`FPSC_OFF_CONF, {16'h0000, bad_op[j]});
      wchk(`FPSC_OFF_CMD, bad_cmd[j]);
      no_op();
      rchk(`FPSC_OFF_CMD, 32'h0000_0000, 32'h0000_0003);
    end
    rchk(`FPSC_OFF_RAW, 32'h0000_0000);
    // Summaries stay at the last read's image through both programs
    old = exp_sum(img, 0);
    for (int b = 0; b < 11; b += 10)
    begin
      rnd_img(4'(b));
      wchk(`FPSC_OFF_CONF, 32'h0000_5A5A);
      wchk(`FPSC_OFF_CMD, {26'h0, b[3:0], 2'b10});
      run_op(1'b1, b[3:0]);
      rchk(`FPSC_OFF_CMD, {26'h0, b[3:0], 2'b00});
      rchk(`FPSC_OFF_MST, 32'h0000_0002);
      wchk(`FPSC_OFF_RAW, 32'h0000_0002);
      rchk(`FPSC_OFF_RAW, 32'h0000_0000);
      rchk(`FPSC_OFF_SUM0, old);
    end
    wr(12'h1F0, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'h0000_0002);
    rd(12'h1F0, d, r);
    chk({d, 30'h0, r}, {32'h0000_0000, 32'h0000_0002});
    tally_and_finish();
  end
endmodule : tb_top
